// ===== hdl/scd_decoder.sv
// strobe capture, header detection and control byte decoding
// assumes all inputs synchronous to clk; endpoints sit outside
// Operation
// - strobe rising: set flag, pulse, capture byte
// - strobe held: drop pulse, keep flag set
// - one-cycle pulse queues one byte to host
// - strobe low: clear flag and captured byte, rearm
// - reset: direction B-to-A, output enable on
// - output enables are active low
// - run bit set: drive run_level high
// - strobe high: float shared port
// - strobe low: re-enable shared port
// - control byte only after 5A C3 7E
// - idle until 5A, then first header
// - expect C3 next, else back to idle
// - expect 7E next, else back to idle
// - decode state takes next byte as control
// - bits 0,2,3,4: run, led, switch, loopback
// - advance once per received byte edge
// - endpoint select is 3-bit, value 2
// - upstream buses or-merged, downstream shared
// - start transfer is loopback or send pulse
// - internal reset held for RST_COUNT+1 clocks
// - strobe edge-detected on the fast clock
`timescale 1ns/1ns
`default_nettype none
module scd_decoder (
  input wire logic clk,
  input wire logic resetn,
  input wire logic write_strobe_pin,
  input wire logic [scd_pkg::BYTE_W-1:0] sample_byte_bus,
  input wire logic [scd_pkg::BYTE_W-1:0] host_byte,
  input wire logic host_byte_valid,
  input wire logic loopback_request,
  input wire logic [scd_pkg::UP_W-1:0] trig_upstream,
  input wire logic [scd_pkg::UP_W-1:0] xfer_upstream,
  input wire logic [scd_pkg::DN_W-1:0] downstream_in,
  output logic sys_ready,
  output logic start_transfer,
  output logic [scd_pkg::BYTE_W-1:0] captured_byte,
  output logic [scd_pkg::ADDR_W-1:0] endpoint_select,
  output logic [scd_pkg::UP_W-1:0] upstream_bus,
  output logic [scd_pkg::DN_W-1:0] downstream_bus,
  output logic port1_direction,
  output logic port1_output_enable_n,
  output logic run_level,
  output logic led_reset,
  output logic switch_reset,
  output logic loopback_enable
);
  import scd_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [RST_CNT_W-1:0] rst_cnt_r;
  logic ready_r;
  logic seen_r;
  logic start_r;
  logic [BYTE_W-1:0] byte_r;
  logic rx_seen_r;
  logic rx_evt;
  logic strobe_evt;
  scd_state_t state_r;
  scd_state_t state_nxt;
  logic [BYTE_W-1:0] ctl_r;
  logic oe_n_r;
  logic dir_r;
  logic [ADDR_W-1:0] sel_r;
  logic [UP_W-1:0] up_r;
  logic [UP_W-1:0] up_nxt;
  logic [DN_W-1:0] dn_r;

  // header step: go to next state on match, otherwise idle
  function automatic scd_state_t hdr_step(
    input logic [7:0] rx,
    input logic [7:0] want,
    input scd_state_t nxt
  );
    hdr_step = (rx == want) ? nxt : SCD_IDLE;
  endfunction

  // ----------------------------------------------------------------
  // internal reset stretcher
  // ----------------------------------------------------------------
  // all but the endpoint bus registers stay cleared until the counter is done
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_cnt_r <= '0;
      ready_r <= 1'b0;
    end else if (rst_cnt_r < RST_COUNT) begin
      rst_cnt_r <= rst_cnt_r + 12'h001;
      ready_r <= 1'b0;
    end else begin
      ready_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // strobe capture
  // ----------------------------------------------------------------
  // strobe is slow against clk; the flag turns its level into an edge
  assign strobe_evt = ready_r & write_strobe_pin & ~seen_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      seen_r <= 1'b0;
      byte_r <= BYTE_RESET;
    end else if (!ready_r) begin
      seen_r <= 1'b0;
      byte_r <= BYTE_RESET;
    end else if (strobe_evt) begin
      seen_r <= 1'b1;
      byte_r <= sample_byte_bus;
    end else if (write_strobe_pin && seen_r) begin
      seen_r <= 1'b1;
    end else if (!write_strobe_pin && seen_r) begin
      seen_r <= 1'b0;
      byte_r <= BYTE_RESET;
    end
  end

  // loopback requests share the start line with the strobe pulse
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      start_r <= 1'b0;
    end else begin
      start_r <= ready_r & (strobe_evt | loopback_request);
    end
  end

  // ----------------------------------------------------------------
  // shared port direction and enable
  // ----------------------------------------------------------------
  // floating the port lets the far side drive its led on these pins
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dir_r <= PORT1_DIR_B_TO_A;
      oe_n_r <= OE_ON_N;
    end else if (!ready_r) begin
      dir_r <= PORT1_DIR_B_TO_A;
      oe_n_r <= OE_ON_N;
    end else if (write_strobe_pin) begin
      oe_n_r <= OE_OFF_N;
    end else begin
      oe_n_r <= OE_ON_N;
    end
  end

  // ----------------------------------------------------------------
  // host byte header detection
  // ----------------------------------------------------------------
  assign rx_evt = ready_r & host_byte_valid & ~rx_seen_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_seen_r <= 1'b0;
    end else if (!ready_r) begin
      rx_seen_r <= 1'b0;
    end else if (rx_evt) begin
      rx_seen_r <= 1'b1;
    end else if (!host_byte_valid) begin
      rx_seen_r <= 1'b0;
    end
  end

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      SCD_IDLE: begin
        if (rx_evt) begin
          state_nxt = hdr_step(host_byte, HDR_BYTE1, SCD_HDR2);
        end
      end
      SCD_HDR2: begin
        if (rx_evt) begin
          state_nxt = hdr_step(host_byte, HDR_BYTE2, SCD_HDR3);
        end
      end
      SCD_HDR3: begin
        if (rx_evt) begin
          state_nxt = hdr_step(host_byte, HDR_BYTE3, SCD_DECODE);
        end
      end
      SCD_DECODE: begin
        if (rx_evt) begin
          state_nxt = SCD_SET;
        end
      end
      SCD_SET: begin
        state_nxt = SCD_IDLE;
      end
      default: begin
        state_nxt = SCD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= SCD_IDLE;
    end else if (!ready_r) begin
      state_r <= SCD_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // control byte
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctl_r <= BYTE_RESET;
    end else if (!ready_r) begin
      ctl_r <= BYTE_RESET;
    end else if (state_r == SCD_DECODE && rx_evt) begin
      ctl_r <= host_byte;
    end
  end

  // ----------------------------------------------------------------
  // endpoint buses
  // ----------------------------------------------------------------
  scd_bus_or_merge u_merge (
    .trig_upstream(trig_upstream),
    .xfer_upstream(xfer_upstream),
    .merged(up_nxt)
  );

  // registered copies cost one cycle of latency on each bus
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      up_r <= UP_RESET;
      dn_r <= DN_RESET;
      sel_r <= ENDPOINT_ADDR;
    end else begin
      up_r <= up_nxt;
      dn_r <= downstream_in;
      sel_r <= ENDPOINT_ADDR;
    end
  end

  assign sys_ready = ready_r;
  assign start_transfer = start_r;
  assign captured_byte = byte_r;
  assign endpoint_select = sel_r;
  assign upstream_bus = up_r;
  assign downstream_bus = dn_r;
  assign port1_direction = dir_r;
  assign port1_output_enable_n = oe_n_r;
  assign run_level = ctl_r[CTL_RUN_BIT];
  assign led_reset = ctl_r[CTL_LED_RST_BIT];
  assign switch_reset = ctl_r[CTL_SW_RST_BIT];
  assign loopback_enable = ctl_r[CTL_LOOP_BIT];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking dc @(posedge clk); endclocking
  default disable iff (!resetn);

  strobe_pulse_a: assert property (
    ready_r && write_strobe_pin && !seen_r
    |=> start_r && seen_r && byte_r == $past(sample_byte_bus))
    else $error("strobe did not pulse and capture");

  pulse_single_a: assert property (
    ready_r && write_strobe_pin && seen_r && !loopback_request
    |=> !start_r && seen_r)
    else $error("send pulse longer than one clock");

  strobe_fall_a: assert property (
    ready_r && !write_strobe_pin && seen_r
    |=> !seen_r && byte_r == BYTE_RESET)
    else $error("flag not cleared on strobe fall");

  oe_float_a: assert property (
    ready_r && write_strobe_pin |=> port1_output_enable_n)
    else $error("shared port not floated");

  oe_restore_a: assert property (
    ready_r && $fell(write_strobe_pin) |=> !port1_output_enable_n)
    else $error("shared port not re-enabled");

  hdr_start_a: assert property (
    state_r == SCD_IDLE && rx_evt && host_byte == HDR_BYTE1
    |=> state_r == SCD_HDR2)
    else $error("first header byte not taken");

  idle_hold_a: assert property (
    state_r == SCD_IDLE && rx_evt && host_byte != HDR_BYTE1
    |=> state_r == SCD_IDLE)
    else $error("idle left without first header byte");

  hdr_seq_a: assert property (
    state_r == SCD_HDR3 && rx_evt && host_byte == HDR_BYTE3
    |=> state_r == SCD_DECODE)
    else $error("header sequence not followed");

  hdr3_miss_a: assert property (
    state_r == SCD_HDR3 && rx_evt && host_byte != HDR_BYTE3
    |=> state_r == SCD_IDLE)
    else $error("bad third byte kept header state");

  ctl_guard_a: assert property (
    !(state_r == SCD_DECODE && rx_evt) |=> $stable(ctl_r))
    else $error("control byte changed without header");

  hdr_miss_a: assert property (
    state_r == SCD_HDR2 && rx_evt && host_byte != HDR_BYTE2
    |=> state_r == SCD_IDLE)
    else $error("bad second byte kept header state");

  decode_set_a: assert property (
    state_r == SCD_DECODE && rx_evt
    |=> state_r == SCD_SET && run_level == $past(host_byte[0])
    ##1 state_r == SCD_IDLE)
    else $error("control byte not decoded");

  ctl_bits_a: assert property (
    state_r == SCD_DECODE && rx_evt
    |=> led_reset == $past(host_byte[CTL_LED_RST_BIT])
    && switch_reset == $past(host_byte[CTL_SW_RST_BIT])
    && loopback_enable == $past(host_byte[CTL_LOOP_BIT]))
    else $error("control bits not decoded");

  byte_once_a: assert property (
    rx_evt |=> !rx_evt)
    else $error("decoder advanced twice on one byte");

  reset_hold_a: assert property (
    ready_r |-> rst_cnt_r == RST_COUNT)
    else $error("internal reset released early");

  port_fixed_a: assert property (
    port1_direction == PORT1_DIR_B_TO_A
    && endpoint_select == ENDPOINT_ADDR)
    else $error("fixed direction or select changed");

  start_loop_a: assert property (
    ready_r && loopback_request |=> start_transfer)
    else $error("loopback request did not start transfer");

  bus_copy_a: assert property (
    1'b1 |=> upstream_bus == $past(trig_upstream | xfer_upstream)
    && downstream_bus == $past(downstream_in))
    else $error("endpoint buses not passed through");

  strobe_cov: cover property (ready_r && start_r && seen_r);
  header_cov: cover property (state_r == SCD_DECODE);
  control_cov: cover property (state_r == SCD_SET && run_level);
  float_cov: cover property ($rose(port1_output_enable_n));

endmodule
`default_nettype wire

// ===== shared/scd_pkg.sv
// constants and types for the strobe capture and control decoder
// assumes a single 50 MHz clock domain
`default_nettype none
package scd_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int BYTE_W = 8;
  localparam int UP_W = 22;
  localparam int DN_W = 24;
  localparam int ADDR_W = 3;
  localparam int RST_CNT_W = 12;

  // ----------------------------------------------------------------
  // header bytes and control byte layout
  // ----------------------------------------------------------------
  localparam logic [7:0] HDR_BYTE1 = 8'h5A;
  localparam logic [7:0] HDR_BYTE2 = 8'hC3;
  localparam logic [7:0] HDR_BYTE3 = 8'h7E;
  localparam int CTL_RUN_BIT = 0;
  localparam int CTL_LED_RST_BIT = 2;
  localparam int CTL_SW_RST_BIT = 3;
  localparam int CTL_LOOP_BIT = 4;

  // ----------------------------------------------------------------
  // reset values and timing counts
  // ----------------------------------------------------------------
  localparam logic [11:0] RST_COUNT = 12'h9C8;
  localparam logic [2:0] ENDPOINT_ADDR = 3'h2;
  localparam logic PORT1_DIR_B_TO_A = 1'b0;
  localparam logic OE_ON_N = 1'b0;
  localparam logic OE_OFF_N = 1'b1;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [21:0] UP_RESET = 22'h000000;
  localparam logic [23:0] DN_RESET = 24'h000000;

  typedef enum logic [2:0] {
    SCD_IDLE = 3'b000,
    SCD_HDR2 = 3'b001,
    SCD_HDR3 = 3'b010,
    SCD_DECODE = 3'b011,
    SCD_SET = 3'b100
  } scd_state_t;

endpackage
`default_nettype wire

// ===== hdl/scd_bus_or_merge.sv
// bus_or_merge: ors the upstream buses of the two endpoints
// assumes each idle endpoint drives all zeros on its upstream bus
`timescale 1ns/1ns
`default_nettype none
module scd_bus_or_merge (
  input wire logic [scd_pkg::UP_W-1:0] trig_upstream,
  input wire logic [scd_pkg::UP_W-1:0] xfer_upstream,
  output logic [scd_pkg::UP_W-1:0] merged
);
  import scd_pkg::*;

  // wired-or without tristates, so neither endpoint fights the other
  assign merged = trig_upstream | xfer_upstream;

endmodule
`default_nettype wire

// ===== tb/scd_partner.sv
// partner: microcontroller strobe pins and host byte channel
// assumes the bench calls its tasks at a falling clock edge
`timescale 1ns/1ns
`default_nettype none
module scd_partner (
  input wire logic clk,
  output logic strobe,
  output logic [7:0] sample,
  output logic [7:0] hbyte,
  output logic hvalid
);
  initial begin
    strobe = 1'b0;
    sample = 8'h00;
    hbyte = 8'h00;
    hvalid = 1'b0;
  end
  // released lines show the inverse, never a stale value
  task automatic strobe_up(input logic [7:0] b);
    strobe = 1'b1;
    sample = b;
  endtask
  task automatic strobe_down();
    strobe = 1'b0;
    sample = ~sample;
  endtask
  // valid held two cycles, then low one cycle before the next byte
  task automatic send_host(input logic [7:0] b);
    @(negedge clk);
    hbyte = b;
    hvalid = 1'b1;
    repeat (2) @(negedge clk);
    hvalid = 1'b0;
    hbyte = ~b;
  endtask
endmodule
`default_nettype wire

// ===== tb/tb_scd_decoder.sv
// bench for the strobe capture and control decoder
// assumes scd_pkg and scd_partner are compiled first
`timescale 1ns/1ns
`default_nettype none
module tb_scd_decoder;
  import scd_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic loop_req = 1'b0;
  logic [21:0] trig = 22'h000000;
  logic [21:0] xfer = 22'h000000;
  logic [23:0] dn = 24'h000000;
  wire logic strobe;
  wire logic hvalid;
  wire logic [7:0] sample;
  wire logic [7:0] hbyte;
  logic start, oe_n, dir, run, ledr, swr, loopen, ready;
  logic [7:0] cap;
  logic [2:0] sel;
  logic [21:0] up;
  logic [23:0] dn_o;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  // ----------------------------------------------------------------
  // clock, partner and design
  // ----------------------------------------------------------------
  always #10 clk = ~clk;
  scd_partner partner_u (.clk(clk), .strobe(strobe), .sample(sample),
    .hbyte(hbyte), .hvalid(hvalid));
  scd_decoder dut_u (.clk(clk), .resetn(resetn),
    .write_strobe_pin(strobe), .sample_byte_bus(sample),
    .host_byte(hbyte), .host_byte_valid(hvalid),
    .loopback_request(loop_req), .trig_upstream(trig),
    .xfer_upstream(xfer), .downstream_in(dn), .sys_ready(ready),
    .start_transfer(start), .captured_byte(cap),
    .endpoint_select(sel), .upstream_bus(up), .downstream_bus(dn_o),
    .port1_direction(dir), .port1_output_enable_n(oe_n),
    .run_level(run), .led_reset(ledr), .switch_reset(swr),
    .loopback_enable(loopen));
  // ----------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // run takes about 2600 cycles; ceiling leaves ample margin
  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    repeat (3) @(negedge clk);
    chk(sel, ENDPOINT_ADDR);
    chk(dir, PORT1_DIR_B_TO_A);
    chk(oe_n, OE_ON_N);
    chk(start, 1'b0);
    $display("test reset done");
  endtask
  task automatic t_strobe(input logic [7:0] b);
    partner_u.strobe_up(b);
    @(negedge clk);
    chk(start, 1'b1);
    chk(cap, b);
    chk(oe_n, OE_OFF_N);
    @(negedge clk);
    chk(start, 1'b0);
    chk(cap, b);
    partner_u.strobe_down();
    @(negedge clk);
    chk(cap, 8'h00);
    chk(oe_n, OE_ON_N);
    $display("test strobe done");
  endtask
  task automatic t_ctl(input logic [7:0] q [5], input int n,
    input logic [7:0] e);
    for (int i = 0; i < n; i++)
      partner_u.send_host(q[i]);
    @(negedge clk);
    chk({loopen, swr, ledr, run}, {e[4], e[3], e[2], e[0]});
    chk(oe_n, OE_ON_N);
    $display("test control done");
  endtask
  task automatic t_bus();
    loop_req = 1'b1;
    trig = 22'h3C0001;
    xfer = 22'h000F02;
    dn = 24'hA5C3E1;
    @(negedge clk);
    chk(start, 1'b1);
    chk(up, 22'h3C0F03);
    chk(dn_o, 24'hA5C3E1);
    loop_req = 1'b0;
    @(negedge clk);
    chk(start, 1'b0);
    $display("test buses done");
  endtask
  initial begin
    int n;
    t_reset();
    repeat (3) @(negedge clk);
    resetn = 1'b1;
    n = 0;
    while (ready !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    chk(24'(n), 24'h0009C9);
    t_strobe(8'hA5);
    t_strobe(8'h3C);
    t_ctl('{HDR_BYTE1, HDR_BYTE2, HDR_BYTE3, 8'h1D, 8'h00}, 4, 8'h1D);
    t_ctl('{8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 1, 8'h1D);
    t_ctl('{8'h5A, 8'h00, 8'hC3, 8'h7E, 8'h00}, 5, 8'h1D);
    t_ctl('{8'h5A, 8'hC3, 8'h00, 8'h7E, 8'h00}, 5, 8'h1D);
    t_ctl('{8'h5A, 8'h5A, 8'hC3, 8'h7E, 8'h00}, 5, 8'h1D);
    t_ctl('{8'h5A, 8'hC3, 8'h7E, 8'hE2, 8'h00}, 4, 8'h00);
    t_ctl('{8'h5A, 8'hC3, 8'h7E, 8'h01, 8'h00}, 4, 8'h01);
    t_bus();
    tally_and_finish();
  end
endmodule
`default_nettype wire
